// ---- hdl/smrs_fifo.sv ----
// Shift-register FIFO with registered head, valid and ready on both sides
`timescale 1ns/1ps
module smrs_fifo #(
    parameter int WIDTH = smrs_pkg::ENTRY_W,
    parameter int DEPTH = smrs_pkg::FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] data;
        logic [DEPTH-1:0] valid;
    } smrs_fifo_state_t;

    smrs_fifo_state_t q;
    smrs_fifo_state_t d;

    // ==========================================================
    // Next state
    always_comb begin
        logic placed;
        placed = 1'b0;
        d = q;
        if (q.valid[0] && out_ready_i) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.data[i] = q.data[i+1];
                d.valid[i] = q.valid[i+1];
            end
            d.valid[DEPTH-1] = 1'b0;
        end
        if (in_valid_i && !q.valid[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!d.valid[i] && !placed) begin
                    d.data[i] = in_data_i;
                    d.valid[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
        if (flush_i) begin
            d.valid = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Ports
    assign in_ready_o = !q.valid[DEPTH-1];
    assign out_valid_o = q.valid[0];
    assign out_data_o = q.data[0];

    always_comb begin
        count_o = '0;
        for (int i = 0; i < DEPTH; i++) begin
            count_o = count_o + ($clog2(DEPTH+1))'(q.valid[i]);
        end
    end

    // ==========================================================
    // Checks
    a_head_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        out_valid_o && !out_ready_i && !flush_i |=> out_valid_o && $stable(out_data_o))
        else $error("fifo head changed while stalled");
    a_full_refuse: assert property (@(posedge clock_i) disable iff (reset_i)
        count_o == ($clog2(DEPTH+1))'(DEPTH) && !out_ready_i && !flush_i
        |-> !in_ready_o ##1 count_o == ($clog2(DEPTH+1))'(DEPTH))
        else $error("fifo ready while full");
endmodule // smrs_fifo

// ---- hdl/smrs_pkg.sv ----
// Constants and types shared by the multi-line receive silo
package smrs_pkg;
    // ==========================================================
    // Clock and bit rates
    localparam int CLOCK_HZ = 10_000_000;
    localparam int RATE_SCALE = 10;
    localparam int RATE_SEL_W = 4;
    localparam int NUM_RATES = 16;
    // Rates in tenths of a baud, indexed by the rate select code
    localparam int RATE_X10 [NUM_RATES] = '{
        500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
        18000, 20000, 24000, 36000, 48000, 72000, 96000, 198000};
    // ==========================================================
    // Character format
    localparam int DATA_W = 8;
    localparam int CHAR_LEN_MIN = 5;
    localparam int LEN_SEL_W = 2;
    localparam int BITN_W = 4;
    localparam int NUM_LINES = 4;
    localparam int LINE_W = 2;
    localparam int SYNC_W = 3;
    // ==========================================================
    // Silo sizes
    localparam int SILO_DEPTH = 64;
    localparam int SILO_ALARM_LEVEL = 16;
    localparam int FIFO_DEPTH = 4;
    // ==========================================================
    // Silo entry layout
    localparam int E_DATA_LSB = 0;
    localparam int E_LINE_LSB = 8;
    localparam int E_FERR = 10;
    localparam int E_PERR = 11;
    localparam int E_OVR = 12;
    localparam int ENTRY_W = 13;
    // ==========================================================
    // Receiver states
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} smrs_rx_state_t;
endpackage

// ---- hdl/smrs_receive_silo.sv ----
// Multi-line receivers, shared receive silo, alarm and interrupt logic
`timescale 1ns/1ps
module smrs_receive_silo #(
    parameter int CLK_HZ = smrs_pkg::CLOCK_HZ,
    parameter int NUM_LINES = smrs_pkg::NUM_LINES,
    parameter int SILO_DEPTH = smrs_pkg::SILO_DEPTH,
    parameter int FIFO_DEPTH = smrs_pkg::FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [NUM_LINES-1:0] rx_serial_i,
    input wire logic [NUM_LINES-1:0] tx_line_i,
    input wire logic [NUM_LINES-1:0] rx_enable_i,
    input wire logic [NUM_LINES*smrs_pkg::RATE_SEL_W-1:0] rate_sel_i,
    input wire logic [NUM_LINES*smrs_pkg::LEN_SEL_W-1:0] char_len_i,
    input wire logic [NUM_LINES-1:0] two_stop_i,
    input wire logic [NUM_LINES-1:0] parity_enable_i,
    input wire logic [NUM_LINES-1:0] parity_odd_i,
    input wire logic maint_i,
    input wire logic silo_alarm_enable_i,
    input wire logic receive_interrupt_enable_i,
    input wire logic device_clear_i,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic [smrs_pkg::DATA_W-1:0] rx_data_o,
    output logic [smrs_pkg::LINE_W-1:0] rx_line_o,
    output logic rx_framing_err_o,
    output logic rx_parity_err_o,
    output logic rx_overrun_o,
    output logic silo_alarm_flag_o,
    output logic overrun_error_flag_o,
    output logic receive_interrupt_o,
    output logic device_clear_bit_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    localparam int RSW = smrs_pkg::RATE_SEL_W;
    localparam int LSW = smrs_pkg::LEN_SEL_W;
    localparam int DW = smrs_pkg::DATA_W;
    localparam int BW = smrs_pkg::BITN_W;
    localparam int EW = smrs_pkg::ENTRY_W;
    localparam int CNT_W = $clog2(CLK_HZ * smrs_pkg::RATE_SCALE / smrs_pkg::RATE_X10[0] + 1);
    localparam int SILO_MEM = SILO_DEPTH - FIFO_DEPTH;
    localparam int AW = $clog2(SILO_MEM);
    localparam int SCW = $clog2(SILO_MEM + 1);
    localparam int FCW = $clog2(FIFO_DEPTH + 1);
    localparam int TW = $clog2(SILO_DEPTH + 1);

    typedef struct packed {
        logic [smrs_pkg::SYNC_W-1:0] sync;
        logic filt;
        smrs_pkg::smrs_rx_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [BW-1:0] bitn;
        logic [DW-1:0] shift;
        logic par;
        logic perr;
        logic ferr;
        logic second;
        logic done;
        logic [DW-1:0] hdata;
        logic hferr;
        logic hperr;
    } smrs_line_t;

    typedef struct packed {
        smrs_line_t [NUM_LINES-1:0] ln;
        logic [SILO_MEM-1:0][EW-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [SCW-1:0] cnt;
        logic ovr_pend;
        logic alarm;
        logic irq;
        logic clr;
    } smrs_state_t;

    smrs_state_t q;
    smrs_state_t d;
    logic [smrs_pkg::NUM_RATES-1:0][CNT_W-1:0] div_tab;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [EW-1:0] fifo_out_data;
    logic [FCW-1:0] fifo_count;
    logic [TW-1:0] silo_total;
    logic take;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        return (p == AW'(SILO_MEM - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // ==========================================================
    // Bit period table
    // rate table
    for (genvar r = 0; r < smrs_pkg::NUM_RATES; r++) begin : g_div
        assign div_tab[r] = CNT_W'(CLK_HZ * smrs_pkg::RATE_SCALE / smrs_pkg::RATE_X10[r]);
    end

    assign silo_total = TW'(q.cnt) + TW'(fifo_count);
    assign fifo_in_valid = (q.cnt != '0) && !q.clr;

    // ==========================================================
    // Next state
    always_comb begin
        logic [CNT_W-1:0] div;
        logic [BW-1:0] len;
        logic src;
        logic tick;
        logic found;
        logic [smrs_pkg::LINE_W-1:0] pick;
        logic store;
        logic push;
        div = '0;
        len = '0;
        src = 1'b1;
        tick = 1'b0;
        found = 1'b0;
        pick = '0;
        store = 1'b0;
        push = 1'b0;
        take = 1'b0;
        d = q;
        for (int i = 0; i < NUM_LINES; i++) begin
            div = div_tab[rate_sel_i[i*RSW +: RSW]];
            len = BW'(smrs_pkg::CHAR_LEN_MIN) + BW'(char_len_i[i*LSW +: LSW]);
            src = maint_i ? tx_line_i[i ^ 1] : q.ln[i].filt;
            d.ln[i].sync = {q.ln[i].sync[smrs_pkg::SYNC_W-2:0], rx_serial_i[i]};
            if (q.ln[i].sync[1] == q.ln[i].sync[2]) begin
                d.ln[i].filt = q.ln[i].sync[2];
            end
            tick = (q.ln[i].cnt == '0);
            if (!tick) begin
                d.ln[i].cnt = q.ln[i].cnt - 1'b1;
            end
            case (q.ln[i].st)
                smrs_pkg::RX_IDLE: begin
                    if (!src) begin
                        d.ln[i].st = smrs_pkg::RX_START;
                        d.ln[i].cnt = div >> 1;
                    end
                end
                smrs_pkg::RX_START: begin
                    if (tick) begin
                        d.ln[i].st = src ? smrs_pkg::RX_IDLE : smrs_pkg::RX_DATA;
                        d.ln[i].cnt = div - 1'b1;
                        d.ln[i].bitn = '0;
                        d.ln[i].par = 1'b0;
                        d.ln[i].second = 1'b0;
                        d.ln[i].ferr = 1'b0;
                        d.ln[i].perr = 1'b0;
                    end
                end
                smrs_pkg::RX_DATA: begin
                    if (tick) begin
                        d.ln[i].shift = {src, q.ln[i].shift[DW-1:1]};
                        d.ln[i].par = q.ln[i].par ^ src;
                        d.ln[i].bitn = q.ln[i].bitn + 1'b1;
                        d.ln[i].cnt = div - 1'b1;
                        if (q.ln[i].bitn + 1'b1 == len) begin
                            d.ln[i].st = parity_enable_i[i] ? smrs_pkg::RX_PARITY
                                                            : smrs_pkg::RX_STOP;
                        end
                    end
                end
                smrs_pkg::RX_PARITY: begin
                    if (tick) begin
                        d.ln[i].perr = q.ln[i].par ^ src ^ parity_odd_i[i];
                        d.ln[i].cnt = div - 1'b1;
                        d.ln[i].st = smrs_pkg::RX_STOP;
                    end
                end
                smrs_pkg::RX_STOP: begin
                    if (tick) begin
                        d.ln[i].cnt = div - 1'b1;
                        if (two_stop_i[i] && !q.ln[i].second) begin
                            d.ln[i].second = 1'b1;
                            d.ln[i].ferr = !src;
                        end else begin
                            d.ln[i].done = 1'b1;
                            d.ln[i].hdata = q.ln[i].shift >> (BW'(DW) - len);
                            d.ln[i].hferr = q.ln[i].ferr | !src;
                            d.ln[i].hperr = q.ln[i].perr;
                            d.ln[i].st = smrs_pkg::RX_IDLE;
                        end
                    end
                end
                default: d.ln[i].st = smrs_pkg::RX_IDLE;
            endcase
            if (!rx_enable_i[i]) begin
                d.ln[i].st = smrs_pkg::RX_IDLE;
            end
            if (q.ln[i].done && !found) begin
                found = 1'b1;
                pick = smrs_pkg::LINE_W'(i);
            end
        end
        take = found && !q.clr;
        if (take) begin
            d.ln[pick].done = 1'b0;
            if (silo_total == TW'(SILO_DEPTH)) begin
                d.ovr_pend = 1'b1;
            end else begin
                store = 1'b1;
                d.mem[q.wr] = {q.ovr_pend, q.ln[pick].hperr, q.ln[pick].hferr, pick,
                               q.ln[pick].hdata};
                d.ovr_pend = 1'b0;
                d.wr = next_ptr(q.wr);
            end
        end
        push = fifo_in_valid && fifo_in_ready;
        if (push) begin
            d.rd = next_ptr(q.rd);
        end
        d.cnt = SCW'(q.cnt + SCW'(store) - SCW'(push));
        d.alarm = (silo_total >= TW'(smrs_pkg::SILO_ALARM_LEVEL));
        d.irq = receive_interrupt_enable_i &&
                (silo_alarm_enable_i ? q.alarm : fifo_out_valid);
        d.clr = device_clear_i;
        if (q.clr) begin
            d.wr = '0;
            d.rd = '0;
            d.cnt = '0;
            d.ovr_pend = 1'b0;
            d.alarm = 1'b0;
            for (int i = 0; i < NUM_LINES; i++) begin
                d.ln[i].done = 1'b0;
                d.ln[i].st = smrs_pkg::RX_IDLE;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            q <= '0;
            for (int i = 0; i < NUM_LINES; i++) begin
                q.ln[i].sync <= '1;
                q.ln[i].filt <= 1'b1;
            end
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Output buffer
    smrs_fifo #(
        .WIDTH(EW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .flush_i(q.clr),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(q.mem[q.rd]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(rx_ready_i),
        .out_data_o(fifo_out_data),
        .count_o(fifo_count)
    );

    assign rx_valid_o = fifo_out_valid;
    assign rx_data_o = fifo_out_data[smrs_pkg::E_DATA_LSB +: DW];
    assign rx_line_o = fifo_out_data[smrs_pkg::E_LINE_LSB +: smrs_pkg::LINE_W];
    assign rx_framing_err_o = fifo_out_data[smrs_pkg::E_FERR];
    assign rx_parity_err_o = fifo_out_data[smrs_pkg::E_PERR];
    assign rx_overrun_o = fifo_out_data[smrs_pkg::E_OVR];
    assign silo_alarm_flag_o = q.alarm;
    assign overrun_error_flag_o = q.ovr_pend;
    assign receive_interrupt_o = q.irq;
    assign device_clear_bit_o = q.clr;

    // ==========================================================
    // Checks
    sequence s_clear_start;
        device_clear_i && !q.clr;
    endsequence
    sequence s_clear_run;
        q.clr ##1 (silo_total == '0);
    endsequence

    a_alarm_set: assert property (silo_total >= TW'(smrs_pkg::SILO_ALARM_LEVEL) && !q.clr
        |=> silo_alarm_flag_o)
        else $error("alarm missing at sixteen");
    a_alarm_quiet: assert property (silo_total < TW'(smrs_pkg::SILO_ALARM_LEVEL)
        |=> !silo_alarm_flag_o)
        else $error("alarm set below sixteen");
    a_overrun_drop: assert property (take && silo_total == TW'(SILO_DEPTH) && !rx_ready_i
        |=> overrun_error_flag_o && silo_total == TW'(SILO_DEPTH))
        else $error("sixty-fifth character not flagged");
    a_sae_mute: assert property (silo_alarm_enable_i && !q.alarm |=> !receive_interrupt_o)
        else $error("per character interrupt not muted");
    a_alarm_irq: assert property (receive_interrupt_enable_i && silo_alarm_enable_i
        && $rose(silo_alarm_flag_o) |=> receive_interrupt_o)
        else $error("alarm interrupt missing");
    a_bit_period: assert property ($past(q.ln[0].st) == smrs_pkg::RX_START &&
        q.ln[0].st == smrs_pkg::RX_DATA && $stable(rate_sel_i[RSW-1:0])
        |-> q.ln[0].cnt == div_tab[rate_sel_i[RSW-1:0]] - 1'b1)
        else $error("bit period wrong");
    a_char_len: assert property (q.ln[0].st == smrs_pkg::RX_STOP && $stable(char_len_i)
        |-> q.ln[0].bitn == BW'(smrs_pkg::CHAR_LEN_MIN) + BW'(char_len_i[LSW-1:0]))
        else $error("character length wrong");
    a_parity_off: assert property ($rose(q.ln[0].done) && !parity_enable_i[0]
        && $stable(parity_enable_i[0]) |-> !q.ln[0].hperr)
        else $error("parity error without parity");
    a_loop_pair: assert property (maint_i && q.ln[1].st == smrs_pkg::RX_IDLE
        && !tx_line_i[0] && rx_enable_i[1] |=> q.ln[1].st == smrs_pkg::RX_START)
        else $error("line one not looped from line zero");
    a_clear_run: assert property (s_clear_start |=> s_clear_run)
        else $error("device clear did not empty silo");
    a_clear_drop: assert property (q.clr && !device_clear_i |=> !device_clear_bit_o)
        else $error("device clear bit stuck");
endmodule // smrs_receive_silo

// ---- verification/smrs_line_model.sv ----
// Serial terminal model driving four asynchronous receive lines
`timescale 1ns/1ps
module smrs_line_model #(
    parameter int CLK_HZ = smrs_pkg::CLOCK_HZ
) (
    input wire logic clock_i,
    output wire logic [3:0] line_o,
    output logic busy_o
);
    // ==========================================================
    // Request word: data, length code, parity, stops, bad stop, rate
    int req_q [4][$];
    wire [3:0] busy_w;
    assign busy_o = |busy_w;
    for (genvar g = 0; g < 4; g++) begin : g_line
        logic bit_q;
        logic busy_q;
        assign line_o[g] = bit_q;
        assign busy_w[g] = busy_q;
        initial begin
            int r;
            int div;
            logic [7:0] d;
            bit bq [$];
            bit_q = 1'h1;
            busy_q = 1'h0;
            forever begin
                wait (req_q[g].size() > 0);
                r = req_q[g].pop_front();
                busy_q = 1'h1;
                div = CLK_HZ * smrs_pkg::RATE_SCALE / smrs_pkg::RATE_X10[r[17:14]];
                d = r[7:0];
                bq = {1'h0};
                for (int i = 0; i < 5 + r[9:8]; i++) begin
                    bq.push_back(d[i]);
                end
                if (r[10]) begin
                    bq.push_back((^d) ^ r[11]);
                end
                // Bad stop is only sent when a scenario asks for it
                bq.push_back(!r[13]);
                if (r[12]) begin
                    bq.push_back(1'h1);
                end
                foreach (bq[i]) begin
                    @(posedge clock_i);
                    bit_q <= bq[i];
                    repeat (div - 1) @(posedge clock_i);
                end
                @(posedge clock_i);
                bit_q <= 1'h1;
                busy_q <= 1'h0;
            end
        end
    end
endmodule // smrs_line_model

// ---- verification/test_serial_mux_receive_silo.sv ----
// Self-checking testbench for the multi-line receive silo
`timescale 1ns/1ps
module test_serial_mux_receive_silo;
    localparam int CLK_HZ = 320000;
    localparam int LIMIT = 90000;
    logic clock_i, reset_i, maint_i, silo_alarm_enable_i, receive_interrupt_enable_i;
    logic device_clear_i, rx_ready_i;
    logic [3:0] rx_enable_i, two_stop_i, parity_enable_i, parity_odd_i;
    logic [15:0] rate_sel_i;
    logic [7:0] char_len_i, rx_data_o;
    logic [1:0] rx_line_o;
    logic rx_valid_o, rx_framing_err_o, rx_parity_err_o, rx_overrun_o;
    logic silo_alarm_flag_o, overrun_error_flag_o, receive_interrupt_o, device_clear_bit_o;
    logic [3:0] line_w;
    logic busy_w;
    wire [3:0] rx_w = maint_i ? 4'hF : line_w;
    wire [3:0] tx_w = maint_i ? line_w : 4'hF;
    wire [10:0] ent_w = {rx_overrun_o, rx_parity_err_o, rx_framing_err_o, rx_data_o};
    int n_fail, check_count, cyc;
    int rt [4], ln [4];
    bit pen [4], odd [4], two [4];
    bit rnd_ready;
    logic [10:0] exp_q [4][$];

    smrs_line_model #(.CLK_HZ(CLK_HZ)) pm_u (.clock_i(clock_i), .line_o(line_w),
        .busy_o(busy_w));
    smrs_receive_silo #(.CLK_HZ(CLK_HZ)) dut_u (.clock_i(clock_i), .reset_i(reset_i),
        .rx_serial_i(rx_w), .tx_line_i(tx_w), .rx_enable_i(rx_enable_i),
        .rate_sel_i(rate_sel_i), .char_len_i(char_len_i), .two_stop_i(two_stop_i),
        .parity_enable_i(parity_enable_i), .parity_odd_i(parity_odd_i), .maint_i(maint_i),
        .silo_alarm_enable_i(silo_alarm_enable_i), .device_clear_i(device_clear_i),
        .receive_interrupt_enable_i(receive_interrupt_enable_i), .rx_ready_i(rx_ready_i),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_line_o(rx_line_o),
        .rx_framing_err_o(rx_framing_err_o), .rx_parity_err_o(rx_parity_err_o),
        .rx_overrun_o(rx_overrun_o), .silo_alarm_flag_o(silo_alarm_flag_o),
        .overrun_error_flag_o(overrun_error_flag_o),
        .receive_interrupt_o(receive_interrupt_o), .device_clear_bit_o(device_clear_bit_o));

    // ==========================================================
    // Clock, timeout and random host ready
    initial begin
        clock_i = 1'h0;
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        rx_ready_i <= rnd_ready & 1'($urandom);
        if (cyc == LIMIT) begin
            n_fail++;
            final_report();
        end
    end

    // ==========================================================
    // Compare tasks and report
    task automatic chk_entry(input logic [10:0] got, input logic [10:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t entry got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t flag got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Host side: every taken entry against the model queues
    always @(posedge clock_i) begin
        if (reset_i === 1'h0 && rx_valid_o === 1'h1 && rx_ready_i === 1'h1) begin
            if (exp_q[rx_line_o].size() == 0) begin
                n_fail++;
                $display("[ERR] t=%0t entry got %h exp %h", $time, ent_w, 11'h0);
            end else begin
                chk_entry(ent_w, exp_q[rx_line_o].pop_front());
            end
        end
    end

    // ==========================================================
    // Line setup, character send and waits
    task automatic setcfg(input int l, input int r, input int n, input bit t, input bit p,
        input bit o);
        rt[l] = r;
        ln[l] = n;
        two[l] = t;
        pen[l] = p;
        odd[l] = o;
        @(posedge clock_i);
        rate_sel_i[4*l +: 4] <= 4'(r);
        char_len_i[2*l +: 2] <= 2'(n);
        two_stop_i[l] <= t;
        parity_enable_i[l] <= p;
        parity_odd_i[l] <= o;
    endtask
    task automatic send(input int l, input bit bad, input bit keep, input bit ovr);
        int r;
        logic [7:0] d;
        r = maint_i ? (l ^ 1) : l;
        d = 8'($urandom) & 8'((1 << (5 + ln[l])) - 1);
        if (keep) begin
            exp_q[r].push_back({ovr, pen[l] & (odd[l] ^ odd[r]), bad, d});
        end
        pm_u.req_q[l].push_back(int'(d) | (ln[l] << 8) | (int'(pen[l]) << 10)
            | (int'(odd[l]) << 11) | (int'(two[l]) << 12) | (int'(bad) << 13) | (rt[l] << 14));
    endtask
    task automatic wait_idle;
        repeat (2) @(posedge clock_i);
        while (busy_w) @(posedge clock_i);
        repeat (12) @(posedge clock_i);
    endtask
    task automatic wait_drain;
        int n;
        n = 0;
        while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size() > 0
            && n < 3000) begin
            @(posedge clock_i);
            n++;
        end
        chk_flag(n < 3000, 1'h1);
        repeat (4) @(posedge clock_i);
        chk_flag(rx_valid_o, 1'h0);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {reset_i, maint_i, silo_alarm_enable_i, device_clear_i} = 4'h8;
        {two_stop_i, parity_enable_i, parity_odd_i, rate_sel_i, char_len_i} = 36'h0;
        rx_enable_i = 4'hF;
        receive_interrupt_enable_i = 1'h1;
        void'($urandom(32'h95FE));
        repeat (8) @(posedge clock_i);
        reset_i <= 1'h0;
        repeat (4) @(posedge clock_i);
        rnd_ready = 1'h1;
        for (int k = 0; k < 4; k++) begin
            for (int l = 0; l < 4; l++) begin
                setcfg(l, 4 * k + l, k, k != 0, k != 0 && l[1], l[0]);
            end
            for (int l = 0; l < 4; l++) begin
                send(l, k == 3 && l == 3, 1'h1, 1'h0);
            end
            wait_idle();
            wait_drain();
        end
        rnd_ready = 1'h0;
        setcfg(0, 15, 3, 1'h0, 1'h0, 1'h0);
        for (int k = 1; k <= 65; k++) begin
            send(0, 1'h0, k <= 64, 1'h0);
            wait_idle();
            chk_flag(silo_alarm_flag_o, k >= 16);
            chk_flag(overrun_error_flag_o, k == 65);
            chk_flag(receive_interrupt_o, k == 1 || k >= 16);
            if (k == 1) begin
                silo_alarm_enable_i <= 1'h1;
            end
        end
        rnd_ready = 1'h1;
        wait_drain();
        chk_flag(silo_alarm_flag_o, 1'h0);
        chk_flag(overrun_error_flag_o, 1'h1);
        send(0, 1'h0, 1'h1, 1'h1);
        wait_idle();
        wait_drain();
        chk_flag(overrun_error_flag_o, 1'h0);
        silo_alarm_enable_i <= 1'h0;
        maint_i <= 1'h1;
        for (int l = 0; l < 4; l++) begin
            setcfg(l, 15, 3, 1'h0, 1'h1, !l[0]);
        end
        for (int l = 0; l < 4; l++) begin
            send(l, 1'h0, 1'h1, 1'h0);
        end
        wait_idle();
        wait_drain();
        maint_i <= 1'h0;
        rnd_ready = 1'h0;
        setcfg(0, 15, 3, 1'h0, 1'h0, 1'h0);
        send(0, 1'h0, 1'h0, 1'h0);
        wait_idle();
        chk_flag(rx_valid_o, 1'h1);
        chk_flag(receive_interrupt_o, 1'h1);
        receive_interrupt_enable_i <= 1'h0;
        repeat (2) @(posedge clock_i);
        chk_flag(receive_interrupt_o, 1'h0);
        receive_interrupt_enable_i <= 1'h1;
        device_clear_i <= 1'h1;
        @(posedge clock_i);
        device_clear_i <= 1'h0;
        #1 chk_flag(device_clear_bit_o, 1'h1);
        repeat (3) @(posedge clock_i);
        #1 chk_flag(device_clear_bit_o, 1'h0);
        chk_flag(rx_valid_o, 1'h0);
        @(posedge clock_i);
        rx_enable_i <= 4'hE;
        send(0, 1'h0, 1'h0, 1'h0);
        wait_idle();
        chk_flag(rx_valid_o, 1'h0);
        rx_enable_i <= 4'hF;
        send(0, 1'h0, 1'h1, 1'h0);
        wait_idle();
        rnd_ready = 1'h1;
        wait_drain();
        final_report();
    end
endmodule // test_serial_mux_receive_silo
